// >>> design/ealu_pkg.sv
// Purpose: shared constants and types for the eight-bit alu datapath
// Assumes: one clock, asynchronous active-low reset
// Notes: flag bit positions follow the status byte layout of the core

package ealu_pkg;

  // ==========================================================
  // widths and sizes
  localparam int EALU_DATA_W = 8;
  localparam int EALU_REGS = 32;
  localparam int EALU_IDX_W = 5;
  localparam int EALU_IOA_W = 6;

  // ==========================================================
  // address limits and constants
  localparam logic [4:0] EALU_WORD_BASE = 5'h18;
  localparam logic [5:0] EALU_IO_BIT_LAST = 6'h1f;
  localparam logic [7:0] EALU_ALL_ONES = 8'hff;
  localparam logic [7:0] EALU_ALL_ZERO = 8'h00;
  localparam logic [7:0] EALU_ONE = 8'h01;

  // ==========================================================
  // status byte fields and reset values
  localparam int EALU_FLAG_C = 0;
  localparam int EALU_FLAG_Z = 1;
  localparam int EALU_FLAG_N = 2;
  localparam int EALU_FLAG_V = 3;
  localparam int EALU_FLAG_S = 4;
  localparam int EALU_FLAG_H = 5;
  localparam logic [7:0] EALU_FLAGS_RST = 8'h00;
  localparam logic [7:0] EALU_REG_RST = 8'h00;

  // ==========================================================
  // operations
  typedef enum logic [4:0] {
    OP_SUM = 5'h00,
    OP_SUM_CARRY = 5'h01,
    OP_WORD_SUM_IMMEDIATE = 5'h02,
    OP_DIFFERENCE = 5'h03,
    OP_DIFFERENCE_IMMEDIATE = 5'h04,
    OP_DIFFERENCE_WITH_BORROW = 5'h05,
    OP_DIFFERENCE_BORROW_IMMEDIATE = 5'h06,
    OP_WORD_DIFFERENCE_IMMEDIATE = 5'h07,
    OP_CONJUNCTION = 5'h08,
    OP_CONJUNCTION_IMMEDIATE = 5'h09,
    OP_DISJUNCTION = 5'h0a,
    OP_DISJUNCTION_IMMEDIATE = 5'h0b,
    OP_BITWISE_XOR = 5'h0c,
    OP_INVERT_ALL_BITS = 5'h0d,
    OP_TWOS_INVERT_PLUS_ONE = 5'h0e,
    OP_SET_BITS_MASK = 5'h0f,
    OP_CLEAR_BITS_MASK = 5'h10,
    OP_STEP_UP_ONE = 5'h11,
    OP_STEP_DOWN_ONE = 5'h12,
    OP_IO_BIT_SET = 5'h13,
    OP_IO_BIT_CLEAR = 5'h14,
    OP_SKIP_IF_IO_BIT_ONE = 5'h15,
    OP_SKIP_IF_IO_BIT_ZERO = 5'h16
  } ealu_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WORD_HIGH = 3'b010,
    ST_IO_TEST = 3'b100
  } ealu_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    ealu_op_t op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
    logic [5:0] io_addr;
    logic [2:0] bit_sel;
  } ealu_req_t;

  typedef struct packed {
    logic bit_write;
    logic read;
    logic [4:0] addr;
    logic [7:0] mask;
    logic value;
  } ealu_io_t;

endpackage : ealu_pkg

// >>> design/ealu_addsub.sv
// Purpose: adder and subtractor with carry, half carry and overflow
// Assumes: purely combinational, used once per cycle by the datapath
// Notes: in subtract mode carry and half carry are borrows

`timescale 1ns/1ns
`default_nettype none

module ealu_addsub #(
  parameter int W = 8
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic cin,
  input wire logic sub,
  output logic [W-1:0] sum,
  output logic carry,
  output logic half,
  output logic ovf
);

  logic [W:0] full;
  logic [4:0] nib;

  always_comb begin
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
      nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    end else begin
      full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    end
    sum = full[W-1:0];
    carry = full[W];
    half = nib[4];
    if (sub) begin
      ovf = (a[W-1] & ~b[W-1] & ~full[W-1]) |
            (~a[W-1] & b[W-1] & full[W-1]);
    end else begin
      ovf = (a[W-1] & b[W-1] & ~full[W-1]) |
            (~a[W-1] & ~b[W-1] & full[W-1]);
    end
  end

endmodule : ealu_addsub

`default_nettype wire

// >>> design/ealu_core.sv
// Purpose: eight-bit alu datapath with register file and io bit access
// Assumes: requests are synchronous to ref_clk and held off while busy
// Notes: word operations use the adder twice, low byte then high byte
//
// What this block does
// - register sum, optional carry, flags, one clock
// - word immediate sum, Z C N V S, two clocks
// - subtract register or immediate, five flags, one clock
// - subtract with borrow also removes carry flag
// - word immediate difference, Z C N V S, two clocks
// - and with register or immediate, Z N V
// - or with register or immediate, Z N V
// - xor of registers, Z N V, one clock
// - ones complement, Z C N V, one clock
// - twos complement, Z C N V H, one clock
// - set mask bits, Z N V, one clock
// - clear mask bits, Z N V, one clock
// - increment or decrement, carry left unchanged
// - bit ops reach io 0x00 to 0x1f only
// - bit set or clear touches only that bit

`timescale 1ns/1ns
`default_nettype none

module ealu_core
  import ealu_pkg::*;
#(
  parameter int REGS = EALU_REGS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire ealu_req_t req,
  input wire logic [4:0] peek_index,
  input wire logic [7:0] io_rdata,
  output logic busy,
  output logic done,
  output logic [7:0] result,
  output logic [7:0] flags,
  output logic skip,
  output logic io_refused,
  output logic [7:0] peek_data,
  output ealu_io_t io
);

  // ==========================================================
  // state
  logic [7:0] regs [REGS];
  ealu_state_t state;
  ealu_state_t next_state;
  logic [4:0] word_hi;
  logic word_sub;
  logic word_cy;
  logic word_lo_zero;
  logic [2:0] test_bit;
  logic test_want;

  logic take;
  logic [7:0] rd_val;
  logic [7:0] rr_val;
  logic [4:0] lo_idx;
  logic [7:0] add_a;
  logic [7:0] add_b;
  logic add_cin;
  logic add_sub;
  logic [7:0] add_sum;
  logic add_c;
  logic add_h;
  logic add_v;
  logic [7:0] next_val;
  logic [4:0] wr_idx;
  logic wr_en;
  logic [7:0] next_flags;
  logic io_ok;

  assign take = req_valid & (state == ST_IDLE);
  assign rd_val = regs[req.dst];
  assign rr_val = regs[req.src];
  assign lo_idx = EALU_WORD_BASE + {2'b00, req.dst[1:0], 1'b0};
  assign io_ok = (req.io_addr <= EALU_IO_BIT_LAST);

  ealu_addsub #(
    .W(EALU_DATA_W)
  ) u_addsub (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sub(add_sub),
    .sum(add_sum),
    .carry(add_c),
    .half(add_h),
    .ovf(add_v)
  );

  // ==========================================================
  // operand selection for the shared adder
  always_comb begin
    add_a = rd_val;
    add_b = rr_val;
    add_cin = 1'b0;
    add_sub = 1'b0;
    if (state == ST_WORD_HIGH) begin
      // second pass: high byte absorbs the low byte carry
      add_a = regs[word_hi];
      add_b = EALU_ALL_ZERO;
      add_cin = word_cy;
      add_sub = word_sub;
    end else begin
      case (req.op)
        OP_SUM_CARRY: add_cin = flags[EALU_FLAG_C];
        OP_WORD_SUM_IMMEDIATE: begin
          add_a = regs[lo_idx];
          add_b = req.imm;
        end
        OP_DIFFERENCE: add_sub = 1'b1;
        OP_DIFFERENCE_IMMEDIATE: begin
          add_b = req.imm;
          add_sub = 1'b1;
        end
        OP_DIFFERENCE_WITH_BORROW: begin
          add_cin = flags[EALU_FLAG_C];
          add_sub = 1'b1;
        end
        OP_DIFFERENCE_BORROW_IMMEDIATE: begin
          add_b = req.imm;
          add_cin = flags[EALU_FLAG_C];
          add_sub = 1'b1;
        end
        OP_WORD_DIFFERENCE_IMMEDIATE: begin
          add_a = regs[lo_idx];
          add_b = req.imm;
          add_sub = 1'b1;
        end
        OP_TWOS_INVERT_PLUS_ONE: begin
          add_a = EALU_ALL_ZERO;
          add_b = rd_val;
          add_sub = 1'b1;
        end
        OP_STEP_UP_ONE: add_b = EALU_ONE;
        OP_STEP_DOWN_ONE: begin
          add_b = EALU_ONE;
          add_sub = 1'b1;
        end
        default: add_sub = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // result and flag update
  always_comb begin
    next_val = add_sum;
    next_flags = flags;
    wr_idx = req.dst;
    wr_en = 1'b0;
    if (state == ST_WORD_HIGH) begin
      wr_idx = word_hi;
      wr_en = 1'b1;
      next_flags[EALU_FLAG_C] = add_c;
      next_flags[EALU_FLAG_V] = add_v;
      next_flags[EALU_FLAG_N] = add_sum[7];
      next_flags[EALU_FLAG_Z] = word_lo_zero & ~|add_sum;
      next_flags[EALU_FLAG_S] = add_sum[7] ^ add_v;
    end else if (take) begin
      case (req.op)
        OP_CONJUNCTION: next_val = rd_val & rr_val;
        OP_CONJUNCTION_IMMEDIATE: next_val = rd_val & req.imm;
        OP_DISJUNCTION: next_val = rd_val | rr_val;
        OP_DISJUNCTION_IMMEDIATE: next_val = rd_val | req.imm;
        OP_BITWISE_XOR: next_val = rd_val ^ rr_val;
        OP_INVERT_ALL_BITS: next_val = EALU_ALL_ONES - rd_val;
        OP_SET_BITS_MASK: next_val = rd_val | req.imm;
        OP_CLEAR_BITS_MASK:
          next_val = rd_val & (EALU_ALL_ONES - req.imm);
        default: next_val = add_sum;
      endcase
      case (req.op)
        OP_SUM, OP_SUM_CARRY, OP_DIFFERENCE, OP_DIFFERENCE_IMMEDIATE,
        OP_DIFFERENCE_WITH_BORROW, OP_DIFFERENCE_BORROW_IMMEDIATE,
        OP_TWOS_INVERT_PLUS_ONE: begin
          wr_en = 1'b1;
          next_flags[EALU_FLAG_C] = add_c;
          next_flags[EALU_FLAG_H] = add_h;
          next_flags[EALU_FLAG_V] = add_v;
        end
        OP_WORD_SUM_IMMEDIATE, OP_WORD_DIFFERENCE_IMMEDIATE: begin
          // low byte written now, flags wait for the high byte
          wr_idx = lo_idx;
          wr_en = 1'b1;
        end
        OP_STEP_UP_ONE, OP_STEP_DOWN_ONE: begin
          wr_en = 1'b1;
          next_flags[EALU_FLAG_V] = add_v;
        end
        OP_INVERT_ALL_BITS: begin
          wr_en = 1'b1;
          next_flags[EALU_FLAG_C] = 1'b1;
          next_flags[EALU_FLAG_V] = 1'b0;
        end
        OP_CONJUNCTION, OP_CONJUNCTION_IMMEDIATE, OP_DISJUNCTION,
        OP_DISJUNCTION_IMMEDIATE, OP_BITWISE_XOR, OP_SET_BITS_MASK,
        OP_CLEAR_BITS_MASK: begin
          wr_en = 1'b1;
          next_flags[EALU_FLAG_V] = 1'b0;
        end
        default: wr_en = 1'b0;
      endcase
      if (wr_en && (req.op != OP_WORD_SUM_IMMEDIATE) &&
          (req.op != OP_WORD_DIFFERENCE_IMMEDIATE)) begin
        next_flags[EALU_FLAG_Z] = (next_val == EALU_ALL_ZERO);
        next_flags[EALU_FLAG_N] = next_val[7];
      end
    end
  end

  // ==========================================================
  // sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && ((req.op == OP_WORD_SUM_IMMEDIATE) ||
                     (req.op == OP_WORD_DIFFERENCE_IMMEDIATE))) begin
          next_state = ST_WORD_HIGH;
        end else if (take && io_ok &&
                     ((req.op == OP_SKIP_IF_IO_BIT_ONE) ||
                      (req.op == OP_SKIP_IF_IO_BIT_ZERO))) begin
          next_state = ST_IO_TEST;
        end
      end
      ST_WORD_HIGH: next_state = ST_IDLE;
      ST_IO_TEST: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      busy <= (next_state != ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_hi <= 5'h00;
      word_sub <= 1'b0;
      word_cy <= 1'b0;
      word_lo_zero <= 1'b0;
      test_bit <= 3'h0;
      test_want <= 1'b0;
    end else if (take) begin
      word_hi <= lo_idx + 5'h01;
      word_sub <= (req.op == OP_WORD_DIFFERENCE_IMMEDIATE);
      word_cy <= add_c;
      word_lo_zero <= (add_sum == EALU_ALL_ZERO);
      test_bit <= req.bit_sel;
      test_want <= (req.op == OP_SKIP_IF_IO_BIT_ONE);
    end
  end

  // ==========================================================
  // register file and flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < REGS; i++) begin
        regs[i] <= EALU_REG_RST;
      end
    end else if (wr_en) begin
      regs[wr_idx] <= next_val;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= EALU_FLAGS_RST;
      result <= EALU_ALL_ZERO;
      peek_data <= EALU_REG_RST;
    end else begin
      flags <= next_flags;
      if (wr_en) begin
        result <= next_val;
      end
      peek_data <= regs[peek_index];
    end
  end

  // ==========================================================
  // completion and skip decision
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
      skip <= 1'b0;
      io_refused <= 1'b0;
    end else begin
      done <= (take && (next_state == ST_IDLE)) || (state != ST_IDLE);
      io_refused <= take && !io_ok && (req.op >= OP_IO_BIT_SET);
      if (state == ST_IO_TEST) begin
        skip <= (io_rdata[test_bit] == test_want);
      end else begin
        skip <= 1'b0;
      end
    end
  end

  // ==========================================================
  // io bit access
  // a lone bit strobe with a one-hot mask, never read-modify-write,
  // so write-one-to-clear flags beside the target bit stay intact
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      io <= '0;
    end else begin
      io.bit_write <= take && io_ok &&
                      ((req.op == OP_IO_BIT_SET) ||
                       (req.op == OP_IO_BIT_CLEAR));
      io.read <= take && io_ok &&
                 ((req.op == OP_SKIP_IF_IO_BIT_ONE) ||
                  (req.op == OP_SKIP_IF_IO_BIT_ZERO));
      if (take) begin
        io.addr <= req.io_addr[4:0];
        io.mask <= EALU_ONE << req.bit_sel;
        io.value <= (req.op == OP_IO_BIT_SET);
      end
    end
  end

endmodule : ealu_core

`default_nettype wire

// >>> verif/ealu_core_assertions.sv
// Purpose: port checker for ealu_core
// Assumes: one clock domain, reset_n asynchronous and active low
// Notes: bound to every ealu_core instance
`timescale 1ns/1ns
`default_nettype none
module ealu_core_assertions
  import ealu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire ealu_req_t req,
  input wire logic busy,
  input wire logic done,
  input wire logic [7:0] result,
  input wire logic [7:0] flags,
  input wire logic skip,
  input wire logic io_refused,
  input wire ealu_io_t io
);
  // ==========================================================
  // helpers
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic take, io_op, word_op, logic_op, strobe_op, test_op, io_ok;
  // a request while busy is ignored, so only this counts as taken
  assign take = req_valid && !busy;
  assign strobe_op = req.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR};
  assign test_op = req.op inside {OP_SKIP_IF_IO_BIT_ONE,
    OP_SKIP_IF_IO_BIT_ZERO};
  assign io_op = strobe_op || test_op;
  assign io_ok = req.io_addr <= EALU_IO_BIT_LAST;
  assign word_op = req.op inside {OP_WORD_SUM_IMMEDIATE,
    OP_WORD_DIFFERENCE_IMMEDIATE};
  assign logic_op = req.op inside {OP_CONJUNCTION, OP_DISJUNCTION,
    OP_CONJUNCTION_IMMEDIATE, OP_DISJUNCTION_IMMEDIATE, OP_BITWISE_XOR,
    OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK};

  // ==========================================================
  // checks
  chk_single_one: assert property (take && !io_op && !word_op
    |=> done && !busy) else $error("byte op not done in one cycle");
  chk_word_two: assert property (take && word_op
    |=> busy && !done ##1 done && !busy)
    else $error("word op not done in two cycles");
  chk_zero_neg: assert property (take && !io_op && !word_op
    |=> flags[EALU_FLAG_Z] == (result == 8'h00)
    && flags[EALU_FLAG_N] == result[7])
    else $error("zero or negative flag wrong");
  chk_carry_kept: assert property (take
    && req.op inside {OP_STEP_UP_ONE, OP_STEP_DOWN_ONE}
    |=> $stable(flags[EALU_FLAG_C])) else $error("step changed carry");
  chk_logic_ovf: assert property (take && logic_op
    |=> !flags[EALU_FLAG_V]) else $error("logic op left overflow set");
  chk_io_strobe: assert property (take && strobe_op && io_ok
    |=> io.bit_write && done && io.mask == (8'h01 << $past(req.bit_sel))
    && io.addr == $past(req.io_addr[4:0])
    && io.value == ($past(req.op) == OP_IO_BIT_SET))
    else $error("io bit strobe wrong");
  chk_io_refuse: assert property (take && io_op && !io_ok
    |=> io_refused && done && !io.bit_write && !io.read)
    else $error("io op above bit range not refused");
  chk_io_test: assert property (take && test_op && io_ok
    |=> io.read && busy && !done ##1 done && !busy)
    else $error("io test timing wrong");
  chk_skip_done: assert property (skip |-> done)
    else $error("skip without done");
endmodule : ealu_core_assertions

bind ealu_core ealu_core_assertions ealu_core_assertions_inst (.ref_clk,
  .reset_n, .req_valid, .req, .busy, .done, .result, .flags, .skip,
  .io_refused, .io);
`default_nettype wire

// >>> verif/ealu_tb_top.sv
// Purpose: self-checking bench for ealu_core
// Assumes: 50 MHz ref_clk, reset_n held low five cycles
// Notes: registers are loaded by and-immediate then or-immediate
`timescale 1ns/1ns
`default_nettype none
module ealu_tb_top
  import ealu_pkg::*;
;
  // ==========================================================
  // design and stimulus
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  ealu_req_t req = '0;
  logic [4:0] peek_index = 5'h00;
  logic [7:0] io_rdata = 8'h00;
  logic busy, done, skip, io_refused;
  logic [7:0] result, flags, peek_data;
  ealu_io_t io;
  int n_errors = 0;
  int cmp_count = 0;
  always #10 ref_clk = ~ref_clk;
  ealu_core ealu_core_inst (.ref_clk, .reset_n, .req_valid, .req,
    .peek_index, .io_rdata, .busy, .done, .result, .flags, .skip,
    .io_refused, .peek_data, .io);

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic go(input ealu_op_t op, input logic [4:0] d,
      input logic [4:0] s, input logic [7:0] k, input logic [5:0] a,
      input logic [2:0] b, input int lat);
    int n;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{op, d, s, k, a, b};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 1;
    #1;
    // bounded wait: a lost done must not hang the run
    while (done !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("latency", 8'(lat), 8'(n));
  endtask : go

  task automatic alu(input ealu_op_t op, input logic [4:0] d,
      input logic [4:0] s, input logic [7:0] k, input int lat,
      input logic [7:0] res, input logic [7:0] f, input logic [7:0] m);
    go(op, d, s, k, 6'h00, 3'h0, lat);
    chk("result", res, result);
    chk("flags", f & m, flags & m);
  endtask : alu

  task automatic load(input logic [4:0] r, input logic [7:0] v);
    go(OP_CONJUNCTION_IMMEDIATE, r, 5'h00, 8'h00, 6'h00, 3'h0, 1);
    go(OP_DISJUNCTION_IMMEDIATE, r, 5'h00, v, 6'h00, 3'h0, 1);
  endtask : load

  task automatic peek(input logic [4:0] r, input logic [7:0] v);
    @(posedge ref_clk);
    peek_index <= r;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("register", v, peek_data);
  endtask : peek

  // ==========================================================
  // scenarios; flag masks: c01 z02 n04 v08 s10 h20
  task automatic t_arith;
    load(5'h01, 8'h0f);
    load(5'h02, 8'h01);
    alu(OP_SUM, 5'h01, 5'h02, 8'h00, 1, 8'h10, 8'h20, 8'h2f);
    load(5'h03, 8'hff);
    alu(OP_SUM, 5'h03, 5'h02, 8'h00, 1, 8'h00, 8'h23, 8'h2f);
    alu(OP_SUM_CARRY, 5'h05, 5'h06, 8'h00, 1, 8'h01, 8'h00, 8'h2f);
    load(5'h07, 8'h10);
    alu(OP_DIFFERENCE_IMMEDIATE, 5'h07, 5'h00, 8'h01, 1, 8'h0f,
      8'h20, 8'h2f);
    alu(OP_DIFFERENCE, 5'h07, 5'h01, 8'h00, 1, 8'hff, 8'h05, 8'h2f);
    alu(OP_DIFFERENCE_BORROW_IMMEDIATE, 5'h08, 5'h00, 8'h00, 1,
      8'hff, 8'h25, 8'h2f);
    alu(OP_DIFFERENCE_WITH_BORROW, 5'h09, 5'h0a, 8'h00, 1,
      8'hff, 8'h25, 8'h2f);
    $display("test arith done");
  endtask : t_arith

  task automatic t_unary;
    load(5'h0d, 8'h01);
    alu(OP_TWOS_INVERT_PLUS_ONE, 5'h0d, 5'h00, 8'h00, 1, 8'hff,
      8'h25, 8'h2f);
    load(5'h0d, 8'h80);
    alu(OP_TWOS_INVERT_PLUS_ONE, 5'h0d, 5'h00, 8'h00, 1, 8'h80,
      8'h0d, 8'h2f);
    load(5'h0d, 8'h00);
    alu(OP_TWOS_INVERT_PLUS_ONE, 5'h0d, 5'h00, 8'h00, 1, 8'h00,
      8'h02, 8'h2f);
    alu(OP_INVERT_ALL_BITS, 5'h0c, 5'h00, 8'h00, 1, 8'hff,
      8'h05, 8'h0f);
    load(5'h0e, 8'h7f);
    alu(OP_STEP_UP_ONE, 5'h0e, 5'h00, 8'h00, 1, 8'h80, 8'h0d, 8'h0f);
    alu(OP_STEP_DOWN_ONE, 5'h0f, 5'h00, 8'h00, 1, 8'hff,
      8'h05, 8'h0f);
    alu(OP_STEP_DOWN_ONE, 5'h0e, 5'h00, 8'h00, 1, 8'h7f,
      8'h09, 8'h0f);
    $display("test unary done");
  endtask : t_unary

  task automatic t_logic;
    // carry is one here and overflow was left set, so carry must stay and overflow clear
    alu(OP_CONJUNCTION_IMMEDIATE, 5'h0b, 5'h00, 8'h00, 1, 8'h00,
      8'h03, 8'h0f);
    alu(OP_DISJUNCTION_IMMEDIATE, 5'h0b, 5'h00, 8'h80, 1, 8'h80,
      8'h05, 8'h0f);
    alu(OP_CONJUNCTION, 5'h0b, 5'h01, 8'h00, 1, 8'h00, 8'h03, 8'h0f);
    alu(OP_DISJUNCTION, 5'h0b, 5'h07, 8'h00, 1, 8'hff, 8'h05, 8'h0f);
    alu(OP_BITWISE_XOR, 5'h0b, 5'h01, 8'h00, 1, 8'hef, 8'h05, 8'h0f);
    alu(OP_CLEAR_BITS_MASK, 5'h0b, 5'h00, 8'hef, 1, 8'h00,
      8'h03, 8'h0f);
    alu(OP_SET_BITS_MASK, 5'h0b, 5'h00, 8'h81, 1, 8'h81,
      8'h05, 8'h0f);
    $display("test logic done");
  endtask : t_logic

  task automatic t_word;
    load(5'h18, 8'hff);
    alu(OP_WORD_SUM_IMMEDIATE, 5'h18, 5'h00, 8'h01, 2, 8'h01,
      8'h00, 8'h1f);
    peek(5'h18, 8'h00);
    alu(OP_WORD_DIFFERENCE_IMMEDIATE, 5'h18, 5'h00, 8'h01, 2,
      8'h00, 8'h00, 8'h1f);
    peek(5'h18, 8'hff);
    alu(OP_WORD_DIFFERENCE_IMMEDIATE, 5'h18, 5'h00, 8'hff, 2,
      8'h00, 8'h02, 8'h1f);
    alu(OP_WORD_DIFFERENCE_IMMEDIATE, 5'h18, 5'h00, 8'h01, 2,
      8'hff, 8'h15, 8'h1f);
    $display("test word done");
  endtask : t_word

  task automatic t_io;
    @(posedge ref_clk);
    io_rdata <= 8'h08;
    go(OP_IO_BIT_SET, 5'h00, 5'h00, 8'h00, 6'h05, 3'h3, 1);
    chk("io mask", 8'h08, io.mask);
    chk("io addr value", 8'h0b, {2'b00, io.addr, io.value});
    go(OP_IO_BIT_CLEAR, 5'h00, 5'h00, 8'h00, 6'h1f, 3'h7, 1);
    chk("io mask", 8'h80, io.mask);
    chk("io addr value", 8'h3e, {2'b00, io.addr, io.value});
    go(OP_IO_BIT_SET, 5'h00, 5'h00, 8'h00, 6'h20, 3'h0, 1);
    chk("io refused", 8'h02, {6'h00, io_refused, io.bit_write});
    go(OP_SKIP_IF_IO_BIT_ONE, 5'h00, 5'h00, 8'h00, 6'h1f, 3'h3, 2);
    chk("skip", 8'h01, {7'h00, skip});
    go(OP_SKIP_IF_IO_BIT_ZERO, 5'h00, 5'h00, 8'h00, 6'h1f, 3'h3, 2);
    chk("skip", 8'h00, {7'h00, skip});
    $display("test io done");
  endtask : t_io

  // ==========================================================
  // sequence and verdict
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_arith();
    t_unary();
    t_logic();
    t_word();
    t_io();
    wrap_up();
  end

  // about 115 cycles of traffic, so this only fires on a hang
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end
endmodule : ealu_tb_top
`default_nettype wire
